// [tb_top.sv]
`timescale 1ns/100ps
// ****************************************************************
// Self-checking bench for the timer control set logic
// ****************************************************************
module tb_top;
  typedef struct packed {
    logic        w;
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] x;
    logic        e;
  } tcs_tb_row_s;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, running, wrap_pulse, ev;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [3:0]  pstrb;
  int          err_total, samples_checked, cycles;
  tcs_tb_row_s rows [12];

  tcs_top #(.CW(8)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .running(running), .wrap_pulse(wrap_pulse));

  // Free running 100 MHz clock
  always #5 pclk = ~pclk;

  // Hang guard, far above the expected run of about 650 cycles
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_total++;
      results();
    end
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
    samples_checked++;
    if (g !== x) begin
      err_total++;
      $display("wrong value at %0t: %s got %h want %h", $time, m, g, x);
    end
  endtask
  // Bus cycle, held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) begin
      @(posedge pclk);
    end
    rdv = prdata;
    ev = pslverr;
    psel <= 1'h0; penable <= 1'h0;
    // One idle edge so the next call never re-drives psel in this time step
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] x, input string m);
    apb(1'h0, a, 32'h0);
    chk(rdv, x, m);
  endtask
  // Bounded waits; a slow prescale needs up to 256 cycles per tick
  task automatic wait_run(input logic lvl);
    int n;
    n = 0;
    while (running !== lvl && n < 700) begin
      n++;
      @(posedge pclk);
    end
  endtask
  task automatic wait_wrap;
    int n;
    n = 0;
    while (wrap_pulse !== 1'h1 && n < 100) begin
      n++;
      @(posedge pclk);
    end
    @(posedge pclk);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    pclk = 1'h0; presetn = 1'h0; psel = 1'h0; penable = 1'h0; pwrite = 1'h0;
    paddr = 12'h0; pwdata = 32'h0; pstrb = 4'hF; err_total = 0; samples_checked = 0; cycles = 0;
    rows = '{'{1'h0, 12'h014, 32'h0, 32'h0, 1'h0}, '{1'h0, 12'h02C, 32'h0, 32'h1, 1'h0},
             '{1'h1, 12'h014, 32'h7, 32'h0, 1'h0}, '{1'h0, 12'h014, 32'h0, 32'h7, 1'h0},
             '{1'h0, 12'h010, 32'h0, 32'h7, 1'h0}, '{1'h1, 12'h014, 32'h0, 32'h0, 1'h0},
             '{1'h0, 12'h014, 32'h0, 32'h7, 1'h0}, '{1'h1, 12'h010, 32'h7, 32'h0, 1'h0},
             '{1'h0, 12'h014, 32'h0, 32'h0, 1'h0}, '{1'h0, 12'h06C, 32'h0, 32'hFF, 1'h0},
             '{1'h0, 12'h100, 32'h0, 32'h0, 1'h1}, '{1'h1, 12'h100, 32'h7, 32'h0, 1'h1}};
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    // Table: reset values, set and clear, zero writes, refused address
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk(rdv, rows[i].x, "table read");
      chk({31'h0, ev}, {31'h0, rows[i].e}, "table error");
    end
    $display("test table done");
    // Slow prescale so a command is seen pending before it runs
    wr(12'h000, 32'h0000_FF02);
    wr(12'h014, 32'h0000_0020);
    rdc(12'h014, 32'h0000_0020, "command pending");
    wait_run(1'h1);
    chk({31'h0, running}, 32'h1, "start");
    rdc(12'h014, 32'h0, "command cleared");
    wr(12'h014, 32'h0000_0040);
    wait_run(1'h0);
    chk({31'h0, running}, 32'h0, "stop");
    rdc(12'h02C, 32'h1, "stopped flag");
    $display("test command done");
    // Fast tick, short period, locked buffer then forced update
    wr(12'h000, 32'h0000_0002);
    wr(12'h06C, 32'h0000_0003);
    wr(12'h014, 32'h0000_0002);
    wr(12'h0BC, 32'h0000_0005);
    rdc(12'h02C, 32'h0000_0009, "buffer valid");
    wr(12'h014, 32'h0000_0020);
    wait_run(1'h1);
    wait_wrap();
    wait_wrap();
    chk({31'h0, running}, 32'h1, "free wrap");
    rdc(12'h06C, 32'h0000_0003, "locked period");
    wr(12'h014, 32'h0000_0060);
    rdc(12'h06C, 32'h0000_0005, "forced update");
    wr(12'h014, 32'h0000_0004);
    wait_wrap();
    repeat (3) @(posedge pclk);
    chk({31'h0, running}, 32'h0, "single run halt");
    rdc(12'h02C, 32'h1, "halt flag");
    wr(12'h014, 32'h0000_0021);
    wait_wrap();
    repeat (3) @(posedge pclk);
    rdc(12'h014, 32'h0000_0007, "down and halted");
    wr(12'h014, 32'h0000_0080);
    rdc(12'h050, 32'h0000_0005, "snapshot");
    $display("test counting done");
    results();
  end
endmodule // tb_top

// [tcs_counter.sv]
`timescale 1ns/100ps
// ****************************************************************
// Up/down counter core with wrap detection
// ****************************************************************
module tcs_counter #(
  parameter int W = 8
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         step,
  input  wire logic         load,
  input  wire logic         dir,
  input  wire logic [W-1:0] top,
  output logic [W-1:0]      value,
  output logic              wrap
);

  // Load restarts from the end the direction begins at
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value <= '0;
      wrap  <= 1'b0;
    end else if (load) begin
      value <= dir ? top : '0;
      wrap  <= 1'b0;
    end else if (step) begin
      wrap <= dir ? (value == '0) : (value >= top);
      if (dir) begin
        value <= (value == '0) ? top : value - W'(1);
      end else begin
        value <= (value >= top) ? '0 : value + W'(1);
      end
    end else begin
      wrap <= 1'b0;
    end
  end

endmodule // tcs_counter

// [tcs_pkg.sv]
// Contract
// - Writing ones to the set register sets those control bits; clear register shows them too.
// - Command field at bits 7:5, single-run bit 2, copy lock bit 1, direction bit 0.
// - A written command runs on the next prescaled kernel clock tick, not at once.
// - After a command has run, the command field reads back as zero.
// - Command zero does nothing; any nonzero command is queued for execution.
// - Command 1 starts, restarts or retriggers the counter; command 2 stops it.
// - Command 3 copies all buffered values into their active registers at once.
// - Command 4 snapshots the counter value so the bus side can read it.
// - Writing one to bit 2 enables single-run; writing zero leaves it alone.
// - Without single-run the counter wraps on overflow or underflow and keeps counting.
// - With single-run the counter wraps on the next overflow or underflow, then halts.
// - While the copy lock is set, hardware update events copy no buffered value.
// - Stopped flag sets when disabled, on stop command, or on single-run wrap.
package tcs_pkg;

  // ****************************************************************
  // Register map, byte addresses are four times the index
  // ****************************************************************
  localparam logic [7:0] TCS_IDX_CTRLA = 8'h00;
  localparam logic [7:0] TCS_IDX_CLR   = 8'h04;
  localparam logic [7:0] TCS_IDX_SET   = 8'h05;
  localparam logic [7:0] TCS_IDX_STAT  = 8'h0B;
  localparam logic [7:0] TCS_IDX_COUNT = 8'h14;
  localparam logic [7:0] TCS_IDX_PER   = 8'h1B;
  localparam logic [7:0] TCS_IDX_PBUF  = 8'h2F;
  localparam int         TCS_ADDR_W    = 12;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int         TCS_DIR_BIT   = 0;
  localparam int         TCS_LOCK_BIT  = 1;
  localparam int         TCS_ONE_BIT   = 2;
  localparam int         TCS_CMD_LSB   = 5;
  localparam int         TCS_EN_BIT    = 1;
  localparam int         TCS_STOP_BIT  = 0;
  localparam int         TCS_PBV_BIT   = 3;
  localparam logic [7:0] TCS_CTRL_RST  = 8'h00;
  localparam logic [7:0] TCS_PER_RST   = 8'hFF;
  localparam logic [7:0] TCS_PRESC_RST = 8'h00;

  typedef enum logic [2:0] {
    TCS_CMD_NONE    = 3'h0,
    TCS_CMD_RETRIG  = 3'h1,
    TCS_CMD_STOP    = 3'h2,
    TCS_CMD_UPDATE  = 3'h3,
    TCS_CMD_SNAP    = 3'h4
  } tcs_cmd_e;

  // Control word carried between bus side and counter
  typedef struct packed {
    logic [2:0] cmd;
    logic       single_run;
    logic       buffer_copy_lock;
    logic       dir;
  } tcs_ctrl_s;

endpackage

// [tcs_prescaler.sv]
`timescale 1ns/100ps
// ****************************************************************
// Prescaled kernel tick: one pulse every div+1 cycles
// ****************************************************************
module tcs_prescaler #(
  parameter int W = 8
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         enable,
  input  wire logic [W-1:0] div,
  output logic              tick
);

  logic [W-1:0] cnt;

  // Elaboration check on the divider width
  if (W < 1) begin : g_bad_w
    $error("tcs_prescaler: W must be positive");
  end

  // Free count while enabled, tick on reaching div
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else if (!enable) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else if (cnt >= div) begin
      cnt  <= '0;
      tick <= 1'b1;
    end else begin
      cnt  <= cnt + W'(1);
      tick <= 1'b0;
    end
  end

endmodule // tcs_prescaler

// [tcs_properties.sv]
`timescale 1ns/100ps
// ****************************************************************
// Port checker for the timer control set logic
// ****************************************************************
module tcs_properties #(
  parameter int CW = 8
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        running,
  input wire logic        wrap_pulse
);
  logic setup, mapped, set_wr, clr_wr, ctl_wr, en_q, one_q;
  // Writes act at the setup edge, so decode them there
  assign setup  = psel && !penable;
  assign mapped = paddr inside {12'h000, 12'h010, 12'h014, 12'h02C, 12'h050, 12'h06C, 12'h0BC};
  assign set_wr = setup && pwrite && pstrb[0] && paddr == 12'h014;
  assign clr_wr = setup && pwrite && pstrb[0] && paddr == 12'h010;
  assign ctl_wr = setup && pwrite && paddr == 12'h000;
  // Shadow of enable, tracked only from bus writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) en_q <= 1'b0;
    else if (ctl_wr) en_q <= pwdata[1];
  end
  // Shadow of single-run: set and clear registers only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) one_q <= 1'b0;
    else if (set_wr && pwdata[2]) one_q <= 1'b1;
    else if (clr_wr && pwdata[2]) one_q <= 1'b0;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_after_setup: assert property (setup |=> pready && psel && penable) else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready held too long");
  a_err_unmapped: assert property (setup && !mapped |=> pslverr) else $error("unmapped not refused");
  a_err_mapped_ok: assert property (setup && mapped |=> !pslverr) else $error("mapped access refused");
  a_err_read_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0000_0000) else $error("refused read not zero");
  a_stop_halts: assert property (set_wr && pwdata[7:5] == 3'h2 |-> ##[1:300] !running) else $error("stop ignored");
  a_retrig_starts: assert property (set_wr && pwdata[7:5] == 3'h1 && en_q |-> ##[1:300] running) else $error("no start");
  a_disabled_idle: assert property ((!en_q) [*3] |-> !running) else $error("runs while disabled");
  a_wrap_continues: assert property (wrap_pulse && !one_q |-> running) else $error("stopped on wrap");
  a_single_halts: assert property (wrap_pulse && one_q |-> ##[0:2] !running) else $error("single run kept going");
  c_retrig: cover property (set_wr && pwdata[7:5] == 3'h1);
  c_wrap_free: cover property (wrap_pulse && !one_q);
  c_wrap_single: cover property (wrap_pulse && one_q);
  c_refused: cover property (pslverr);
endmodule // tcs_properties

bind tcs_top tcs_properties #(.CW(CW)) u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .running(running), .wrap_pulse(wrap_pulse));

// [tcs_top.sv]
// Our own choice: the APB register port.
`timescale 1ns/100ps
// ****************************************************************
// Timer control set/clear logic with APB slave
// ****************************************************************
module tcs_top #(
  parameter int CW = 8
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             running,
  output logic             wrap_pulse
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  tcs_pkg::tcs_ctrl_s ctrl;
  logic               enable;
  logic [7:0]         presc_div;
  logic [CW-1:0]      per;
  logic [CW-1:0]      per_buf;
  logic               per_buf_valid;
  logic [CW-1:0]      snapshot;
  logic               stopped;
  logic               tick;
  logic               cnt_load;
  logic               cnt_step;
  logic [CW-1:0]      cnt_value;
  logic               cnt_wrap;
  logic               wr_en;
  logic               rd_en;
  logic [9:0]         idx;
  logic               hit;
  logic               set_wr;
  logic               clr_wr;
  logic [7:0]         wbyte;
  logic               cmd_run;
  logic               do_update;
  logic [31:0]        next_prdata;

  // Elaboration check: the read mux packs a count into one 32-bit word
  if (CW < 1 || CW > 32) begin : g_bad_cw
    $error("tcs_top: CW must be 1..32");
  end

  // ****************************************************************
  // APB decode, word index is address divided by four
  // ****************************************************************
  assign idx    = paddr[11:2];
  assign wr_en  = psel && !penable && pwrite;
  assign rd_en  = psel && !penable && !pwrite;
  assign wbyte  = pstrb[0] ? pwdata[7:0] : 8'h00;
  assign set_wr = wr_en && hit && idx == 10'(tcs_pkg::TCS_IDX_SET);
  assign clr_wr = wr_en && hit && idx == 10'(tcs_pkg::TCS_IDX_CLR);

  // Mapped index check, anything else answers with pslverr
  always_comb begin
    case (idx)
      10'(tcs_pkg::TCS_IDX_CTRLA), 10'(tcs_pkg::TCS_IDX_CLR), 10'(tcs_pkg::TCS_IDX_SET),
      10'(tcs_pkg::TCS_IDX_STAT), 10'(tcs_pkg::TCS_IDX_COUNT), 10'(tcs_pkg::TCS_IDX_PER),
      10'(tcs_pkg::TCS_IDX_PBUF): hit = 1'b1;
      default:                    hit = 1'b0;
    endcase
  end

  // Registers act in the setup cycle so access phase always lasts one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !hit;
    end
  end

  // ****************************************************************
  // Control bits: set register and clear register share one store
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl.dir              <= 1'b0;
      ctrl.buffer_copy_lock <= 1'b0;
      ctrl.single_run       <= 1'b0;
    end else if (set_wr) begin
      if (wbyte[tcs_pkg::TCS_DIR_BIT])  ctrl.dir <= 1'b1;
      if (wbyte[tcs_pkg::TCS_LOCK_BIT]) ctrl.buffer_copy_lock <= 1'b1;
      if (wbyte[tcs_pkg::TCS_ONE_BIT])  ctrl.single_run <= 1'b1;
    end else if (clr_wr) begin
      if (wbyte[tcs_pkg::TCS_DIR_BIT])  ctrl.dir <= 1'b0;
      if (wbyte[tcs_pkg::TCS_LOCK_BIT]) ctrl.buffer_copy_lock <= 1'b0;
      if (wbyte[tcs_pkg::TCS_ONE_BIT])  ctrl.single_run <= 1'b0;
    end
  end

  // Pending command, retired on the next kernel tick
  assign cmd_run = tick && ctrl.cmd != tcs_pkg::TCS_CMD_NONE;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl.cmd <= 3'h0;
    end else if ((set_wr || clr_wr) && wbyte[tcs_pkg::TCS_CMD_LSB +: 3] != 3'h0) begin
      ctrl.cmd <= set_wr ? wbyte[tcs_pkg::TCS_CMD_LSB +: 3] : 3'h0;
    end else if (cmd_run || !enable) begin
      ctrl.cmd <= 3'h0;
    end
  end

  // ****************************************************************
  // Own control: enable, prescaler divide, period and buffer
  // ****************************************************************
  assign do_update = (cmd_run && ctrl.cmd == tcs_pkg::TCS_CMD_UPDATE) ||
                     (cnt_wrap && per_buf_valid && !ctrl.buffer_copy_lock);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable        <= 1'b0;
      presc_div     <= tcs_pkg::TCS_PRESC_RST;
      per           <= CW'(tcs_pkg::TCS_PER_RST);
      per_buf       <= CW'(tcs_pkg::TCS_PER_RST);
      per_buf_valid <= 1'b0;
    end else begin
      if (wr_en && idx == 10'(tcs_pkg::TCS_IDX_CTRLA)) begin
        enable    <= pwdata[tcs_pkg::TCS_EN_BIT];
        presc_div <= pwdata[15:8];
      end
      if (wr_en && idx == 10'(tcs_pkg::TCS_IDX_PER)) per <= pwdata[CW-1:0];
      if (wr_en && idx == 10'(tcs_pkg::TCS_IDX_PBUF)) begin
        per_buf       <= pwdata[CW-1:0];
        per_buf_valid <= 1'b1;
      end else if (do_update) begin
        per           <= per_buf;
        per_buf_valid <= 1'b0;
      end else if (wr_en && idx == 10'(tcs_pkg::TCS_IDX_STAT) && ctrl.buffer_copy_lock &&
                   pwdata[tcs_pkg::TCS_PBV_BIT]) begin
        per_buf_valid <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Run state and counter
  // ****************************************************************
  tcs_prescaler #(
    .W (8)
  ) u_presc (
    .pclk    (pclk),
    .presetn (presetn),
    .enable  (enable),
    .div     (presc_div),
    .tick    (tick)
  );

  assign cnt_load = cmd_run && ctrl.cmd == tcs_pkg::TCS_CMD_RETRIG;
  // A single-run wrap must not step again while the stop flag lands
  assign cnt_step = tick && !stopped && !cnt_load && !(cnt_wrap && ctrl.single_run);

  tcs_counter #(
    .W (CW)
  ) u_cnt (
    .pclk    (pclk),
    .presetn (presetn),
    .step    (cnt_step),
    .load    (cnt_load),
    .dir     (ctrl.dir),
    .top     (per),
    .value   (cnt_value),
    .wrap    (cnt_wrap)
  );

  // Stopped flag; a wrap keeps running unless single-run is set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stopped <= 1'b1;
    end else if (!enable) begin
      stopped <= 1'b1;
    end else if (cmd_run && ctrl.cmd == tcs_pkg::TCS_CMD_STOP) begin
      stopped <= 1'b1;
    end else if (cnt_load) begin
      stopped <= 1'b0;
    end else if (cnt_wrap && ctrl.single_run) begin
      stopped <= 1'b1;
    end
  end

  // Snapshot only on request, so bus reads see a stable count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      snapshot <= '0;
    end else if (cmd_run && ctrl.cmd == tcs_pkg::TCS_CMD_SNAP) begin
      snapshot <= cnt_value;
    end
  end

  // Status outputs; wrap without single-run just flags, counter continues
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      running    <= 1'b0;
      wrap_pulse <= 1'b0;
    end else begin
      running    <= enable && !stopped;
      wrap_pulse <= cnt_wrap;
    end
  end

  // ****************************************************************
  // Read mux, set and clear read back the same control byte
  // ****************************************************************
  always_comb begin
    next_prdata = 32'h0000_0000;
    case (idx)
      10'(tcs_pkg::TCS_IDX_CLR),
      10'(tcs_pkg::TCS_IDX_SET): begin
        next_prdata[7:0] = {ctrl.cmd, 2'b00, ctrl.single_run, ctrl.buffer_copy_lock, ctrl.dir};
      end
      10'(tcs_pkg::TCS_IDX_CTRLA): next_prdata[15:0] = {presc_div, 6'h00, enable, 1'b0};
      10'(tcs_pkg::TCS_IDX_STAT):  next_prdata[7:0] = {4'h0, per_buf_valid, 2'b00, stopped};
      10'(tcs_pkg::TCS_IDX_COUNT): next_prdata[CW-1:0] = snapshot;
      10'(tcs_pkg::TCS_IDX_PER):   next_prdata[CW-1:0] = per;
      10'(tcs_pkg::TCS_IDX_PBUF):  next_prdata[CW-1:0] = per_buf;
      default:                     next_prdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      prdata <= next_prdata;
    end
  end

endmodule // tcs_top
